// ==== sp8_deser.sv ====
// 1:8 serial to parallel deserializer with bit slip, gating and word framing
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - assemble eight serial bits per parallel word
// - rate select high rising only, else both
// - unconnected rate select means double-edge mode
// - select chooses input a or b, a default
// - all control inputs read low when open
// - master reset stops internal clock regardless gate
// - first capture on second rising after release
// - double-edge latency six clock cycles to output
// - rising-only latency twelve clock cycles to output
// - slip pulse swallows one bit, shifts boundary
// - double-edge slip held two cycles, next edge
// - rising-only slip held three cycles, next rising
// - one bit shift per slip pulse only
// - frame clock divide four double, eight rising
// - gate high suspends activity, no runt pulses
// - resume after gate low, fall, then rising
module sp8_deser #(
  parameter int FIFO_DEPTH = sp8_pkg::FIFO_DEPTH
) (
  // system clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial side pins, asynchronous to clock
  input wire logic ser_clk,
  input wire logic serial_in_a,
  input wire logic serial_in_b,
  // control pins, asynchronous to clock
  input wire logic serial_input_select,
  input wire logic rate_mode_select,
  input wire logic clock_gate_n,
  input wire logic bit_slip_pulse,
  input wire logic master_reset,
  // parallel side
  output logic [sp8_pkg::WORD_W-1:0] parallel_word,
  output logic word_frame_clock,
  // buffered word stream
  output logic word_valid,
  input wire logic word_ready,
  output logic [sp8_pkg::WORD_W-1:0] word_data,
  // status
  output logic word_overflow
);

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("sp8_deser: FIFO_DEPTH must be at least 2");
  end

  sp8_pkg::sp8_state_s s_q, s_d;
  sp8_pkg::sp8_pins_s pins;
  logic fifo_in_ready;
  logic rising_only;
  logic sclk_rise;
  logic sclk_fall;
  logic tick;
  logic data_bit;
  logic [1:0] slip_need;

  // extra sample ticks from last bit of a word until it is shown
  function automatic logic [sp8_pkg::CNT_W-1:0] extra_ticks(input logic rise_only);
    int lat_ticks;
    lat_ticks = rise_only ? sp8_pkg::LAT_RISE_CYC
                          : sp8_pkg::LAT_DOUBLE_CYC * sp8_pkg::EDGES_PER_CYC_DOUBLE;
    return sp8_pkg::CNT_W'(lat_ticks - (sp8_pkg::WORD_W - 1));
  endfunction : extra_ticks

  // open pins are pulled low outside; low picks double edge and input a
  always_comb begin
    pins.ser_clk = ser_clk;
    pins.serial_in_a = serial_in_a;
    pins.serial_in_b = serial_in_b;
    pins.serial_input_select = serial_input_select;
    pins.rate_mode_select = rate_mode_select;
    pins.clock_gate_n = clock_gate_n;
    pins.bit_slip_pulse = bit_slip_pulse;
    pins.master_reset = master_reset;
  end

  assign rising_only = s_q.sync2.rate_mode_select;
  assign sclk_rise = s_q.sync2.ser_clk && !s_q.sclk_prev;
  assign sclk_fall = !s_q.sync2.ser_clk && s_q.sclk_prev;
  // low rate select samples both edges
  assign tick = (s_q.phase == sp8_pkg::SP8_RUN) && (sclk_rise || (!rising_only && sclk_fall));
  // input select, open select reads low so input a
  assign data_bit = s_q.sync2.serial_input_select ? s_q.sync2.serial_in_b
                                                  : s_q.sync2.serial_in_a;
  assign slip_need = rising_only ? 2'(sp8_pkg::SLIP_HOLD_RISE) : 2'(sp8_pkg::SLIP_HOLD_DOUBLE);

  always_comb begin
    s_d = s_q;
    // the first stage is read only by the second
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.sclk_prev = s_q.sync2.ser_clk;
    // a word the FIFO took this clock leaves the push stage
    if (fifo_in_ready) begin
      s_d.push_v = 1'b0;
    end

    // master reset halts and realigns all but the shown word and the push stage
    if (s_q.sync2.master_reset) begin
      s_d.phase = sp8_pkg::SP8_HALT;
      s_d.skip_first = 1'b1;
      s_d.shift = sp8_pkg::WORD_RESET;
      s_d.idx = sp8_pkg::IDX_FIRST;
      s_d.pend_v = 1'b0;
      s_d.frame = 1'b1;
      s_d.slip_cnt = sp8_pkg::SLIP_CNT_ZERO;
      s_d.slip_armed = 1'b0;
      s_d.slip_used = 1'b0;
      s_d.overflow = 1'b0;
    // gate suspends, state is kept for resume
    end else if (s_q.sync2.clock_gate_n) begin
      s_d.phase = sp8_pkg::SP8_HALT;
    end else begin
      case (s_q.phase)
        sp8_pkg::SP8_HALT: begin
          s_d.phase = sp8_pkg::SP8_WAIT_FALL;
        end
        // wait for a falling edge first
        sp8_pkg::SP8_WAIT_FALL: begin
          if (sclk_fall) begin
            s_d.phase = s_q.skip_first ? sp8_pkg::SP8_SKIP_RISE : sp8_pkg::SP8_RUN;
            s_d.skip_first = 1'b0;
          end
        end
        // skip a whole period, so both modes take the second rise
        sp8_pkg::SP8_SKIP_RISE: begin
          if (sclk_fall) begin
            s_d.phase = sp8_pkg::SP8_RUN;
          end
        end
        sp8_pkg::SP8_RUN: begin
          s_d.phase = sp8_pkg::SP8_RUN;
        end
        default: begin
          s_d.phase = sp8_pkg::SP8_HALT;
        end
      endcase

      // count slip hold in serial clock cycles
      if (!s_q.sync2.bit_slip_pulse) begin
        s_d.slip_cnt = sp8_pkg::SLIP_CNT_ZERO;
        s_d.slip_used = 1'b0;
      end else if (!s_q.slip_used && sclk_rise) begin
        s_d.slip_cnt = s_q.slip_cnt + 2'(1);
        if (s_q.slip_cnt + 2'(1) >= slip_need) begin
          s_d.slip_armed = 1'b1;
          s_d.slip_used = 1'b1;
        end
      end

      if (tick) begin
        // latency countdown runs on sample ticks
        if (s_q.pend_v) begin
          s_d.pend_cnt = s_q.pend_cnt - sp8_pkg::CNT_W'(1);
          if (s_q.pend_cnt == sp8_pkg::CNT_LOAD_AT) begin
            s_d.pend_v = 1'b0;
            s_d.out_word = s_q.pend_word;
            s_d.push_word = s_q.pend_word;
            s_d.push_v = 1'b1;
            // a word still waiting for the FIFO is lost
            if (s_q.push_v && !fifo_in_ready) begin
              s_d.overflow = 1'b1;
            end
          end
        end
        // swallow this edge, boundary moves by one
        if (s_q.slip_armed) begin
          s_d.slip_armed = 1'b0;
        end else begin
          // first bit lands in bit zero
          s_d.shift[s_q.idx] = data_bit;
          s_d.idx = s_q.idx + sp8_pkg::IDX_W'(1);
          if (s_q.idx == sp8_pkg::IDX_LAST) begin
            s_d.pend_word = s_q.shift;
            s_d.pend_word[sp8_pkg::IDX_LAST] = data_bit;
            s_d.pend_cnt = extra_ticks(rising_only);
            s_d.pend_v = 1'b1;
          end
          // one frame period per eight samples
          s_d.frame = (s_d.idx < sp8_pkg::IDX_FRAME_HALF);
        end
      end
    end

  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.phase <= sp8_pkg::SP8_HALT;
      s_q.skip_first <= 1'b1;
      s_q.frame <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign parallel_word = s_q.out_word;
  assign word_frame_clock = s_q.frame;
  assign word_overflow = s_q.overflow;

  sp8_fifo #(
    .WIDTH(sp8_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(s_q.push_v),
    .in_ready(fifo_in_ready),
    .in_data(s_q.push_word),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

endmodule : sp8_deser

`default_nettype wire

// ==== sp8_deser_chk.sv ====
// port-level assertions for the deserializer, bound to its top
`timescale 1ns/1ps
`default_nettype none
module sp8_deser_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched inputs
  input wire logic ser_clk,
  input wire logic clock_gate_n,
  input wire logic master_reset,
  input wire logic word_ready,
  // watched outputs
  input wire logic [sp8_pkg::WORD_W-1:0] parallel_word,
  input wire logic word_frame_clock,
  input wire logic word_valid,
  input wire logic [sp8_pkg::WORD_W-1:0] word_data,
  input wire logic word_overflow
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  rst_vals_a: assert property (disable iff (1'b0) rst |=>
    parallel_word == sp8_pkg::WORD_RESET && word_frame_clock && !word_valid && !word_overflow)
    else $error("reset values wrong");
  mrst_clear_a: assert property (master_reset [*6] |-> word_frame_clock && !word_overflow)
    else $error("master reset did not clear");
  mrst_hold_a: assert property (master_reset [*6] |-> $stable(parallel_word))
    else $error("word moved under master reset");
  gate_hold_a: assert property (clock_gate_n [*6] |->
    $stable(parallel_word) && $stable(word_frame_clock)) else $error("activity while gated");
  // sync delay is three clocks, so six quiet cycles leave nothing in flight
  idle_quiet_a: assert property (disable iff (rst || master_reset) $stable(ser_clk) [*6] |->
    $stable(parallel_word) && $stable(word_frame_clock)) else $error("activity without edge");
  load_low_a: assert property ($changed(parallel_word) |-> !word_frame_clock)
    else $error("word loaded in high half");
  frame_high_a: assert property (disable iff (rst || master_reset)
    $rose(word_frame_clock) |-> word_frame_clock [*8]) else $error("frame high too short");
  frame_low_a: assert property (disable iff (rst || master_reset)
    $fell(word_frame_clock) |-> !word_frame_clock [*8]) else $error("frame low too short");
  stall_hold_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("head word lost while stalled");
  ovf_sticky_a: assert property (word_overflow && !master_reset |=> word_overflow)
    else $error("overflow flag dropped");
endmodule : sp8_deser_chk
bind sp8_deser sp8_deser_chk u_chk (.clock(clock), .rst(rst), .ser_clk(ser_clk),
  .clock_gate_n(clock_gate_n), .master_reset(master_reset), .word_ready(word_ready),
  .parallel_word(parallel_word), .word_frame_clock(word_frame_clock),
  .word_valid(word_valid), .word_data(word_data), .word_overflow(word_overflow));
`default_nettype wire

// ==== sp8_fifo.sv ====
// word FIFO between the deserializer and the parallel word receiver
`timescale 1ns/1ps
`default_nettype none

module sp8_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("sp8_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } sp8_fifo_state_s;

  sp8_fifo_state_s s_q, s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.count != CW'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr_ptr] = in_data;
      s_d.wr_ptr = s_q.wr_ptr + PW'(1);
    end
    if (pop) begin
      s_d.rd_ptr = s_q.rd_ptr + PW'(1);
    end
    if (push && !pop) begin
      s_d.count = s_q.count + CW'(1);
    end else if (pop && !push) begin
      s_d.count = s_q.count - CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sp8_fifo

`default_nettype wire

// ==== sp8_pkg.sv ====
// shared constants and carrier types for the 1:8 deserializer
package sp8_pkg;

  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int IDX_W = 3;
  localparam int CNT_W = 4;
  // slip request hold, in serial clock cycles, per rate mode
  localparam int SLIP_HOLD_DOUBLE = 2;
  localparam int SLIP_HOLD_RISE = 3;
  // serial-bit to parallel-output latency, in serial clock cycles
  localparam int LAT_DOUBLE_CYC = 6;
  localparam int LAT_RISE_CYC = 12;
  localparam int EDGES_PER_CYC_DOUBLE = 2;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
  localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
  localparam logic [IDX_W-1:0] IDX_FRAME_HALF = 3'h4;
  localparam logic [CNT_W-1:0] CNT_LOAD_AT = 4'h1;
  localparam logic [1:0] SLIP_CNT_ZERO = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;

  typedef enum logic [2:0] {
    SP8_HALT,
    SP8_WAIT_FALL,
    SP8_SKIP_RISE,
    SP8_RUN
  } sp8_phase_e;

  // every pin-level input, carried through the synchroniser together
  typedef struct packed {
    logic ser_clk;
    logic serial_in_a;
    logic serial_in_b;
    logic serial_input_select;
    logic rate_mode_select;
    logic clock_gate_n;
    logic bit_slip_pulse;
    logic master_reset;
  } sp8_pins_s;

  typedef struct packed {
    sp8_pins_s sync1;
    sp8_pins_s sync2;
    logic sclk_prev;
    sp8_phase_e phase;
    logic skip_first;
    logic [WORD_W-1:0] shift;
    logic [IDX_W-1:0] idx;
    logic pend_v;
    logic [CNT_W-1:0] pend_cnt;
    logic [WORD_W-1:0] pend_word;
    logic [WORD_W-1:0] out_word;
    logic frame;
    logic [1:0] slip_cnt;
    logic slip_armed;
    logic slip_used;
    logic push_v;
    logic [WORD_W-1:0] push_word;
    logic overflow;
  } sp8_state_s;

endpackage : sp8_pkg

// ==== sp8_src.sv ====
// serial data source with a bit clock that stands still between bursts
`timescale 1ns/1ps
`default_nettype none
module sp8_src (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [1:0] rnd,
  // serial pins
  output logic ser_clk = 1'b1,
  output logic serial_in_a = 1'b0,
  output logic serial_in_b = 1'b0,
  output logic edge_p = 1'b0
);
  logic [1:0] cnt_q = 2'h0;
  // parks high after a rise, so a restart always opens with a fall
  always @(posedge clock) begin
    if (rst) begin
      cnt_q <= 2'h0;
      ser_clk <= 1'b1;
      edge_p <= 1'b0;
    end else if (!run && ser_clk && cnt_q == 2'h0) begin
      edge_p <= 1'b0;
      serial_in_a <= ~serial_in_a;
      serial_in_b <= ~serial_in_b;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      edge_p <= (cnt_q == 2'h3);
      if (cnt_q == 2'h3) ser_clk <= ~ser_clk;
      // data moves mid half period, well away from the edge
      if (cnt_q == 2'h1) {serial_in_a, serial_in_b} <= rnd;
    end
  end
endmodule : sp8_src
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the deserializer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic [1:0] rnd = 2'h0;
  logic serial_input_select = 1'b0;
  logic rate_mode_select = 1'b0;
  logic clock_gate_n = 1'b0;
  logic bit_slip_pulse = 1'b0;
  logic master_reset = 1'b0;
  logic word_ready = 1'b0;
  logic hold_rdy = 1'b1;
  logic no_cmp = 1'b0;
  logic swallow = 1'b0;
  logic ser_clk, serial_in_a, serial_in_b, edge_p, word_frame_clock, word_valid, word_overflow;
  logic [sp8_pkg::WORD_W-1:0] parallel_word, word_data, wbuf, last_w;
  logic [sp8_pkg::WORD_W-1:0] shown_w = sp8_pkg::WORD_RESET;
  logic [sp8_pkg::WORD_W-1:0] exp_q[$];
  int seed = 72171;
  int mismatches = 0;
  int samples_checked = 0;
  int skip_n = 0, idx = 0, lat = 0, pw_cnt = 0;
  sp8_src u_src (.clock(clock), .rst(rst), .run(run), .rnd(rnd), .ser_clk(ser_clk),
    .serial_in_a(serial_in_a), .serial_in_b(serial_in_b), .edge_p(edge_p));
  sp8_deser #(.FIFO_DEPTH(sp8_pkg::FIFO_DEPTH)) u_dut (.clock(clock), .rst(rst),
    .ser_clk(ser_clk), .serial_in_a(serial_in_a), .serial_in_b(serial_in_b),
    .serial_input_select(serial_input_select), .rate_mode_select(rate_mode_select),
    .clock_gate_n(clock_gate_n), .bit_slip_pulse(bit_slip_pulse), .master_reset(master_reset),
    .parallel_word(parallel_word), .word_frame_clock(word_frame_clock), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .word_overflow(word_overflow));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    rnd <= 2'($random(seed));
    word_ready <= hold_rdy ? 1'b0 : 1'($random(seed));
  end
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", what, e, g);
      mismatches++;
    end
  endtask : check
  // expected stream, worked out from the edges the source really made
  always @(negedge clock) begin
    if (!no_cmp && word_valid === 1'b1 && word_ready === 1'b1) begin
      check("word_data", exp_q.pop_front(), word_data);
    end
    if (pw_cnt == 1) begin
      check("parallel_word", last_w, parallel_word);
      shown_w = last_w;
    end
    if (pw_cnt > 0) pw_cnt--;
    if (edge_p === 1'b1) begin
      if (skip_n > 0) skip_n--;
      else if (ser_clk || !rate_mode_select) begin
        // the latency countdown runs on every sample edge, a swallowed one too
        if (lat > 0) begin
          lat--;
          if (lat == 0) begin
            check("parallel_word_early", shown_w, parallel_word);
            pw_cnt = 6;
          end
        end
        if (swallow) swallow = 1'b0;
        else begin
          wbuf[idx] = serial_input_select ? serial_in_b : serial_in_a;
          idx = (idx + 1) % 8;
          if (idx == 0) begin
            exp_q.push_back(wbuf);
            last_w = wbuf;
            lat = 5;
          end
        end
      end
    end
  end
  task automatic clocks(input int n);
    repeat (n) @(posedge clock);
  endtask : clocks
  task automatic stop_src();
    run <= 1'b0;
    clocks(12);
  endtask : stop_src
  task automatic align();
    stop_src();
    master_reset <= 1'b1;
    clocks(8);
    master_reset <= 1'b0;
    clocks(6);
    if (lat > 0) void'(exp_q.pop_back());
    lat = 0;
    idx = 0;
    swallow = 1'b0;
    skip_n = 3;
    run <= 1'b1;
  endtask : align
  task automatic slip();
    int n;
    n = rate_mode_select ? sp8_pkg::SLIP_HOLD_RISE : sp8_pkg::SLIP_HOLD_DOUBLE;
    @(negedge clock iff (edge_p === 1'b1 && ser_clk === 1'b0));
    @(posedge clock) bit_slip_pulse <= 1'b1;
    repeat (n) @(negedge clock iff (edge_p === 1'b1 && ser_clk === 1'b1));
    @(posedge clock);
    swallow = 1'b1;
    bit_slip_pulse <= 1'b0;
  endtask : slip
  task automatic gate_gap();
    stop_src();
    clock_gate_n <= 1'b1;
    clocks(8);
    clock_gate_n <= 1'b0;
    clocks(6);
    skip_n = 1;
    run <= 1'b1;
  endtask : gate_gap
  task automatic drain_wait();
    int k;
    stop_src();
    hold_rdy <= 1'b0;
    for (k = 0; k < 3000 && word_valid !== 1'b0; k++) @(negedge clock);
    @(posedge clock);
  endtask : drain_wait
  task automatic cfg(input logic m, input logic s, input int t);
    rate_mode_select <= m;
    serial_input_select <= s;
    align();
    clocks(t);
    slip();
    clocks(t);
    gate_gap();
    clocks(t);
    drain_wait();
    check("words_left", 8'(lat > 0), 8'(exp_q.size()));
  endtask : cfg
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clocks(30000);
    mismatches++;
    end_of_test();
  end
  initial begin
    clocks(5);
    rst <= 1'b0;
    hold_rdy <= 1'b0;
    clocks(2);
    check("parallel_word", sp8_pkg::WORD_RESET, parallel_word);
    check("word_frame_clock", 8'h01, 8'(word_frame_clock));
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 2; s++) begin
        cfg(1'(m), 1'(s), 200 * (m + 1));
      end
    end
    no_cmp = 1'b1;
    hold_rdy <= 1'b1;
    rate_mode_select <= 1'b0;
    align();
    clocks(36 * 32);
    check("word_overflow", 8'h01, 8'(word_overflow));
    drain_wait();
    check("overflow_kept", 8'h01, 8'(word_overflow));
    align();
    stop_src();
    check("overflow_clear", 8'h00, 8'(word_overflow));
    end_of_test();
  end
endmodule : tb
`default_nettype wire
